// ==== design/iaf_core.sv ====
// indirect address generator with pointer registers and alu flag register
`timescale 1ns/1ps
module iaf_core import iaf_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // data access request from the execution core
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic [11:0] acc_addr_i,
  input wire logic [7:0] acc_wdata_i,
  input wire logic [7:0] working_accum_i,
  // data memory
  output logic mem_valid_o,
  output logic mem_write_o,
  output logic [11:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  // read answer to the core
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  // alu
  input wire logic alu_valid_i,
  input wire iaf_alu_op_e alu_op_i,
  input wire logic [7:0] alu_a_i,
  input wire logic [7:0] alu_b_i,
  output logic alu_done_o,
  output logic [7:0] alu_result_o,
  output logic [7:0] alu_flags_o
);

  function automatic logic is_port(input logic [11:0] a);
    return a[11:6] == PORT_PAGE && a[5:3] < 3'(PTR_COUNT) && a[2:0] <= LAST_PORT_SLOT;
  endfunction : is_port

  function automatic logic is_ptr_byte(input logic [11:0] a, input int n, input logic hi);
    return a[11:6] == PORT_PAGE && a[5:3] == 3'(n) && a[2:0] == (hi ? PTR_HI_SLOT : PTR_LO_SLOT);
  endfunction : is_ptr_byte

  logic [11:0] ptr [PTR_COUNT];
  logic [4:0] flags;

  // address resolution
  logic dir_port;
  logic [1:0] dir_sel;
  iaf_port_kind_e dir_kind;
  logic [11:0] cur;
  logic [11:0] eff;
  logic [11:0] stepped;
  logic step_en;
  logic eff_null;
  logic eff_int;
  logic [7:0] int_rdata;
  logic wr_int;
  logic null_rd;

  always_comb begin
    dir_port = is_port(acc_addr_i);
    dir_sel = acc_addr_i[4:3];
    dir_kind = iaf_port_kind_e'(acc_addr_i[2:0]);
    cur = PTR_RESET;
    for (int n = 0; n < PTR_COUNT; n++) begin
      if (dir_sel == 2'(n)) begin
        cur = ptr[n];
      end
    end
    eff = acc_addr_i;
    stepped = cur;
    step_en = 1'b0;
    if (dir_port) begin
      unique case (dir_kind)
        KIND_PLAIN: begin
          eff = cur;
        end
        KIND_STEP_DOWN: begin
          eff = cur;
          stepped = cur - 12'h001;
          step_en = 1'b1;
        end
        KIND_STEP_UP: begin
          eff = cur;
          stepped = cur + 12'h001;
          step_en = 1'b1;
        end
        KIND_PRE_UP: begin
          eff = cur + 12'h001;
          stepped = cur + 12'h001;
          step_en = 1'b1;
        end
        KIND_INDEXED: begin
          eff = cur + {{4{working_accum_i[7]}}, working_accum_i};
        end
      endcase
    end
    eff_null = dir_port && is_port(eff);
    eff_int = eff == FLAGS_ADDR;
    int_rdata = {3'h0, flags};
    for (int n = 0; n < PTR_COUNT; n++) begin
      if (is_ptr_byte(eff, n, 1'b0)) begin
        eff_int = 1'b1;
        int_rdata = ptr[n][7:0];
      end
      if (is_ptr_byte(eff, n, 1'b1)) begin
        eff_int = 1'b1;
        int_rdata = {4'h0, ptr[n][11:8]};
      end
    end
    wr_int = acc_valid_i && acc_write_i && !eff_null && eff_int;
    null_rd = acc_valid_i && !acc_write_i && eff_null;
  end

  // apb decode
  logic apb_unmapped;
  logic apb_wr;
  logic [2:0] apb_idx;

  always_comb begin
    apb_idx = paddr_i[4:2];
    apb_unmapped = paddr_i >= APB_ADDR_LIMIT || paddr_i[1:0] != 2'h0;
    apb_wr = psel_i && penable_i && pwrite_i && !apb_unmapped;
  end

  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && apb_unmapped;

  // read data is latched in the setup phase, so the access phase needs no wait
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      prdata_o <= 32'h0000_0000;
      if (!apb_unmapped) begin
        if (apb_idx == REG_FLAGS) begin
          prdata_o <= {27'h0, flags};
        end else begin
          for (int n = 0; n < PTR_COUNT; n++) begin
            if (apb_idx == REG_PTR0_LO + 3'(2 * n)) begin
              prdata_o <= {24'h0, ptr[n][7:0]};
            end
            if (apb_idx == REG_PTR0_LO + 3'(2 * n + 1)) begin
              prdata_o <= {28'h0, ptr[n][11:8]};
            end
          end
        end
      end
    end
  end

  // pointers: core write, then automatic step, then apb write
  for (genvar g = 0; g < PTR_COUNT; g++) begin : g_ptr
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        ptr[g] <= PTR_RESET;
      end else if (wr_int && is_ptr_byte(eff, g, 1'b0)) begin
        ptr[g][7:0] <= acc_wdata_i;
      end else if (wr_int && is_ptr_byte(eff, g, 1'b1)) begin
        ptr[g][11:8] <= acc_wdata_i[3:0];
      end else if (acc_valid_i && step_en && dir_sel == 2'(g)) begin
        ptr[g] <= stepped;
      end else if (apb_wr && apb_idx == REG_PTR0_LO + 3'(2 * g)) begin
        ptr[g][7:0] <= pwdata_i[7:0];
      end else if (apb_wr && apb_idx == REG_PTR0_LO + 3'(2 * g + 1)) begin
        ptr[g][11:8] <= pwdata_i[3:0];
      end
    end
  end

  // memory stage: null and internal targets never reach memory
  logic s1_rd;
  logic s1_null;
  logic s1_int;
  logic [7:0] s1_int_data;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_valid_o <= 1'b0;
      mem_write_o <= 1'b0;
      mem_addr_o <= 12'h000;
      mem_wdata_o <= 8'h00;
      s1_rd <= 1'b0;
      s1_null <= 1'b0;
      s1_int <= 1'b0;
      s1_int_data <= 8'h00;
    end else begin
      mem_valid_o <= acc_valid_i && !eff_null && !eff_int;
      mem_write_o <= acc_write_i;
      mem_addr_o <= eff;
      mem_wdata_o <= acc_wdata_i;
      s1_rd <= acc_valid_i && !acc_write_i;
      s1_null <= eff_null;
      s1_int <= eff_int;
      s1_int_data <= int_rdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
    end else begin
      rd_valid_o <= s1_rd;
      if (s1_null) begin
        rd_data_o <= 8'h00;
      end else if (s1_int) begin
        rd_data_o <= s1_int_data;
      end else begin
        rd_data_o <= mem_rdata_i;
      end
    end
  end

  // alu and flag computation
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] res;
  logic [4:0] calc;
  logic [4:0] upd;

  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    res = alu_b_i;
    calc = flags;
    upd = 5'h00;
    unique case (alu_op_i)
      ALU_ADD: begin
        sum = {1'b0, alu_a_i} + {1'b0, alu_b_i};
        nib = {1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]};
        res = sum[7:0];
        calc[FLAG_OV] = alu_a_i[7] == alu_b_i[7] && res[7] != alu_a_i[7];
        upd = 5'h1F;
      end
      ALU_SUB: begin
        sum = {1'b0, alu_a_i} + {1'b0, ~alu_b_i} + 9'h001;
        nib = {1'b0, alu_a_i[3:0]} + {1'b0, ~alu_b_i[3:0]} + 5'h01;
        res = sum[7:0];
        calc[FLAG_OV] = alu_a_i[7] != alu_b_i[7] && res[7] != alu_a_i[7];
        upd = 5'h1F;
      end
      ALU_LOGIC: begin
        upd = 5'h14;
      end
      ALU_ROL: begin
        res = {alu_a_i[6:0], flags[FLAG_C]};
        calc[FLAG_DC] = alu_a_i[3];
        calc[FLAG_C] = alu_a_i[7];
        upd = 5'h17;
      end
      ALU_ROR: begin
        res = {flags[FLAG_C], alu_a_i[7:1]};
        calc[FLAG_DC] = alu_a_i[4];
        calc[FLAG_C] = alu_a_i[0];
        upd = 5'h17;
      end
      ALU_NONE: begin
        upd = 5'h00;
      end
    endcase
    if (alu_op_i == ALU_ADD || alu_op_i == ALU_SUB) begin
      calc[FLAG_DC] = nib[4];
      calc[FLAG_C] = sum[8];
    end
    calc[FLAG_N] = res[7];
    calc[FLAG_Z] = res == 8'h00;
    if (!alu_valid_i) begin
      upd = 5'h00;
    end
  end

  // per bit: alu result, then null-read zero, then core write, then apb write
  for (genvar b = 0; b < 5; b++) begin : g_flag
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        flags[b] <= FLAGS_RESET[b];
      end else if (upd[b]) begin
        flags[b] <= calc[b];
      end else if (null_rd && b == FLAG_Z) begin
        flags[b] <= 1'b1;
      end else if (wr_int && eff == FLAGS_ADDR) begin
        flags[b] <= acc_wdata_i[b];
      end else if (apb_wr && apb_idx == REG_FLAGS) begin
        flags[b] <= pwdata_i[b];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      alu_done_o <= 1'b0;
      alu_result_o <= 8'h00;
    end else begin
      alu_done_o <= alu_valid_i;
      alu_result_o <= res;
    end
  end

  assign alu_flags_o = {3'h0, flags};

  // checks
  logic self_wr;
  assign self_wr = wr_int && eff[11:6] == PORT_PAGE && eff[5:3] == {1'b0, dir_sel};

  property p_step_up;
    @(posedge clk_i) disable iff (!rst_b_i)
    acc_valid_i && dir_port && dir_kind == KIND_STEP_UP && !self_wr
    |=> ptr[$past(dir_sel)] == 12'($past(cur) + 12'h001);
  endproperty
  a_step_up: assert property (p_step_up) else $error("step-up pointer wrong");

  property p_step_down;
    @(posedge clk_i) disable iff (!rst_b_i)
    acc_valid_i && dir_port && dir_kind == KIND_STEP_DOWN && !self_wr
    |=> ptr[$past(dir_sel)] == 12'($past(cur) - 12'h001) && mem_addr_o == $past(cur);
  endproperty
  a_step_down: assert property (p_step_down) else $error("step-down wrong");

  property p_plain_keep;
    @(posedge clk_i) disable iff (!rst_b_i)
    acc_valid_i && dir_port && dir_kind == KIND_PLAIN && !wr_int && !apb_wr
    |=> ptr[$past(dir_sel)] == $past(cur) && mem_addr_o == $past(cur);
  endproperty
  a_plain_keep: assert property (p_plain_keep) else $error("plain port moved");

  property p_pre_up;
    @(posedge clk_i) disable iff (!rst_b_i)
    acc_valid_i && dir_port && dir_kind == KIND_PRE_UP
    |=> mem_addr_o == 12'($past(cur) + 12'h001);
  endproperty
  a_pre_up: assert property (p_pre_up) else $error("pre-step address wrong");

  property p_indexed;
    @(posedge clk_i) disable iff (!rst_b_i)
    acc_valid_i && dir_port && dir_kind == KIND_INDEXED
    |=> mem_addr_o == 12'($past(cur) + {{4{$past(working_accum_i[7])}}, $past(working_accum_i)});
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  property p_null_read;
    @(posedge clk_i) disable iff (!rst_b_i)
    null_rd && !alu_valid_i |=> flags[FLAG_Z] ##1 rd_valid_o && rd_data_o == 8'h00;
  endproperty
  a_null_read: assert property (p_null_read) else $error("null read not zero");

  property p_null_write;
    @(posedge clk_i) disable iff (!rst_b_i)
    acc_valid_i && acc_write_i && eff_null && !alu_valid_i && !apb_wr
    |=> !mem_valid_o && $stable(flags);
  endproperty
  a_null_write: assert property (p_null_write) else $error("null write acted");

  property p_add_carry;
    @(posedge clk_i) disable iff (!rst_b_i)
    alu_valid_i && alu_op_i == ALU_ADD
    |=> flags[FLAG_C] == ($past({1'b0, alu_a_i}) + $past({1'b0, alu_b_i}) > 9'h0FF);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

  property p_sub_borrow;
    @(posedge clk_i) disable iff (!rst_b_i)
    alu_valid_i && alu_op_i == ALU_SUB
    |=> flags[FLAG_C] == ($past(alu_a_i) >= $past(alu_b_i)) && alu_done_o;
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("sub borrow wrong");

  property p_flag_write_blocked;
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_int && eff == FLAGS_ADDR && alu_valid_i && alu_op_i != ALU_NONE
    |=> flags[FLAG_Z] == (alu_result_o == 8'h00) && flags[FLAG_N] == alu_result_o[7];
  endproperty
  a_flag_write_blocked: assert property (p_flag_write_blocked) else $error("flag write won");

  property p_upper_zero;
    @(posedge clk_i) disable iff (!rst_b_i)
    alu_flags_o[7:5] == 3'h0 && prdata_o[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("flag bits 7:5 set");

  c_step_up: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    acc_valid_i && dir_port && dir_kind == KIND_STEP_UP);
  c_null_read: cover property (@(posedge clk_i) disable iff (!rst_b_i) null_rd);
  c_self_write: cover property (@(posedge clk_i) disable iff (!rst_b_i) self_wr && step_en);
  c_wrap: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    acc_valid_i && dir_port && dir_kind == KIND_STEP_UP && cur == 12'hFFF);

endmodule : iaf_core

// ==== design/iaf_pkg.sv ====
// constants and types for indirect address generation and alu flags
// Notes on behaviour
// - virtual port access goes to an address formed from its pointer; port holds nothing
// - three 12-bit pointers, each a high and a low byte
// - indirect read aimed at a virtual port returns 00h and sets zero flag
// - indirect write aimed at a virtual port does nothing, flags unchanged
// - five ports per pointer; plain port uses pointer, leaves it unchanged
// - step-down port uses pointer, then decrements it by one
// - step-up port uses pointer, then increments it by one
// - before-step-up port increments pointer first, then uses new value
// - indexed port uses pointer plus signed accumulator; neither is modified
// - automatic pointer steps never touch any flag
// - pointer steps work on all 12 bits, carrying between bytes
// - indirect write to a pointer's own byte beats its pending step
// - flag writes ignored for bits the same instruction computes
// - flag bits 7 to 5 read as zero
// - bit 4 follows result msb
// - bit 3 flags signed overflow of the 7-bit magnitude
// - bit 2 set when result is zero, else cleared
// - add/subtract: bit 1 is carry out of low nibble
// - add/subtract: bit 0 is carry out of result msb
// - subtract adds two's complement, so carries are inverted borrows
// - rotates load half carry from bit 4 or 3, carry from end bit
package iaf_pkg;
  localparam int PTR_COUNT = 3;
  localparam int ADDR_W = 12;
  // data-space map of the virtual ports, pointer bytes and flag register
  localparam logic [5:0] PORT_PAGE = 6'h3F;
  localparam logic [2:0] PTR_LO_SLOT = 3'h5;
  localparam logic [2:0] PTR_HI_SLOT = 3'h6;
  localparam logic [2:0] LAST_PORT_SLOT = 3'h4;
  localparam logic [11:0] FLAGS_ADDR = 12'hFD8;
  // flag bit positions
  localparam int FLAG_N = 4;
  localparam int FLAG_OV = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_DC = 1;
  localparam int FLAG_C = 0;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [11:0] PTR_RESET = 12'h000;
  // apb register indices (byte address is index times four)
  localparam logic [2:0] REG_PTR0_LO = 3'h0;
  localparam logic [2:0] REG_FLAGS = 3'h6;
  localparam logic [7:0] APB_ADDR_LIMIT = 8'h1C;
  typedef enum logic [2:0] {
    KIND_PLAIN,
    KIND_STEP_DOWN,
    KIND_STEP_UP,
    KIND_PRE_UP,
    KIND_INDEXED
  } iaf_port_kind_e;
  typedef enum logic [2:0] {
    ALU_NONE,
    ALU_ADD,
    ALU_SUB,
    ALU_LOGIC,
    ALU_ROL,
    ALU_ROR
  } iaf_alu_op_e;
endpackage : iaf_pkg

// ==== test/iaf_mem_model.sv ====
// data memory model behind the address generator
`timescale 1ns/1ps
module iaf_mem_model (
  // clock
  input wire logic clk_i,
  // access from the block
  input wire logic mem_valid_i,
  input wire logic mem_write_i,
  input wire logic [11:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  // read data
  output logic [7:0] mem_rdata_o
);
  logic [7:0] mem [4096];
  logic [7:0] last;
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0] ^ 8'h5A;
    end
    last = 8'h00;
  end
  // idle bus shows the inverse of its last value, so a late sample cannot pass
  assign mem_rdata_o = mem_valid_i ? mem[mem_addr_i] : ~last;
  always @(posedge clk_i) begin
    if (mem_valid_i) begin
      last <= mem_rdata_o;
      if (mem_write_i) begin
        mem[mem_addr_i] <= mem_wdata_i;
      end
    end
  end
endmodule : iaf_mem_model

// ==== test/test_iaf_core.sv ====
// self-checking bench for the indirect address generator and alu flags
`timescale 1ns/1ps
module test_iaf_core import iaf_pkg::*; ;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic acc_valid_i = 1'b0;
  logic acc_write_i = 1'b0;
  logic [11:0] acc_addr_i = 12'h000;
  logic [7:0] acc_wdata_i = 8'h00;
  logic [7:0] working_accum_i = 8'h00;
  logic alu_valid_i = 1'b0;
  iaf_alu_op_e alu_op_i = ALU_NONE;
  logic [7:0] alu_a_i = 8'h00;
  logic [7:0] alu_b_i = 8'h00;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, mem_valid_o, mem_write_o, rd_valid_o, alu_done_o;
  logic [11:0] mem_addr_o;
  logic [7:0] mem_wdata_o, mem_rdata_i, rd_data_o, alu_result_o, alu_flags_o;
  int err_count = 0;
  int n_compared = 0;
  logic [34:0] tbl [7] = '{
    {ALU_ADD, 8'h7F, 8'h01, 8'h80, 8'h1A}, {ALU_ADD, 8'hFF, 8'h01, 8'h00, 8'h07},
    {ALU_SUB, 8'h05, 8'h05, 8'h00, 8'h07}, {ALU_SUB, 8'h00, 8'h01, 8'hFF, 8'h10},
    {ALU_ROL, 8'h88, 8'h00, 8'h10, 8'h03}, {ALU_ROR, 8'h11, 8'h00, 8'h88, 8'h13},
    {ALU_LOGIC, 8'h00, 8'h00, 8'h00, 8'h07}};

  iaf_core dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i), .acc_addr_i(acc_addr_i),
    .acc_wdata_i(acc_wdata_i), .working_accum_i(working_accum_i),
    .mem_valid_o(mem_valid_o), .mem_write_o(mem_write_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .alu_valid_i(alu_valid_i), .alu_op_i(alu_op_i),
    .alu_a_i(alu_a_i), .alu_b_i(alu_b_i), .alu_done_o(alu_done_o),
    .alu_result_o(alu_result_o), .alu_flags_o(alu_flags_o));
  iaf_mem_model mem_u (.clk_i(clk_i), .mem_valid_i(mem_valid_o), .mem_write_i(mem_write_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

  always #50 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    chk(d, exp, "apb read");
    chk(e, ee, "apb error");
  endtask : rdc

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, v, d, e);
  endtask : wr

  task automatic setp(input int n, input logic [11:0] v);
    wr(8'(8 * n), {24'h0, v[7:0]});
    wr(8'(8 * n + 4), {28'h0, v[11:8]});
  endtask : setp

  task automatic chkp(input int n, input logic [11:0] v);
    rdc(8'(8 * n), {24'h0, v[7:0]}, 1'b0);
    rdc(8'(8 * n + 4), {28'h0, v[11:8]}, 1'b0);
  endtask : chkp

  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] wd,
                     input logic ev, input logic [11:0] ea, input logic [7:0] ed);
    @(posedge clk_i);
    acc_valid_i <= 1'b1;
    acc_write_i <= w;
    acc_addr_i <= a;
    acc_wdata_i <= wd;
    @(posedge clk_i);
    acc_valid_i <= 1'b0;
    #1;
    chk(mem_valid_o, ev, "mem valid");
    if (ev) begin
      chk(mem_addr_o, ea, "mem addr");
      chk(mem_write_o, w, "mem dir");
      if (w) chk(mem_wdata_o, wd, "mem data");
    end
    if (!w) begin
      @(posedge clk_i);
      #1;
      chk(rd_valid_o, 1'b1, "read valid");
      chk(rd_data_o, ed, "read data");
    end
  endtask : acc

  // memory read with the model's preset pattern
  task automatic rdp(input logic [11:0] port, input logic [11:0] ea);
    acc(1'b0, port, 8'h00, 1'b1, ea, ea[7:0] ^ 8'h5A);
  endtask : rdp

  task automatic t_regs;
    chkp(0, PTR_RESET);
    rdc(8'h18, 32'h0, 1'b0);
    rdc(8'h1C, 32'h0, 1'b1);
    wr(8'h18, 32'hFF);
    rdc(8'h18, 32'h1F, 1'b0);
    wr(8'h18, 32'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_steps;
    setp(0, 12'h0FF);
    rdp(12'hFC2, 12'h0FF);
    chkp(0, 12'h100);
    rdp(12'hFC1, 12'h100);
    chkp(0, 12'h0FF);
    rdp(12'hFC3, 12'h100);
    chkp(0, 12'h100);
    setp(0, 12'h001);
    rdp(12'hFC1, 12'h001);
    chk(alu_flags_o, 8'h00, "flags after step");
    rdp(12'hFC1, 12'h000);
    chkp(0, 12'hFFF);
    rdp(12'hFC2, 12'hFFF);
    chkp(0, 12'h000);
    $display("test steps done");
  endtask : t_steps

  task automatic t_index;
    setp(1, 12'h010);
    working_accum_i <= 8'hFE;
    rdp(12'hFCC, 12'h00E);
    chkp(1, 12'h010);
    setp(1, 12'hFFE);
    working_accum_i <= 8'h05;
    rdp(12'hFCC, 12'h003);
    $display("test index done");
  endtask : t_index

  task automatic t_plain;
    setp(1, 12'h200);
    acc(1'b1, 12'hFC8, 8'hA5, 1'b1, 12'h200, 8'h00);
    acc(1'b0, 12'hFC8, 8'h00, 1'b1, 12'h200, 8'hA5);
    chkp(1, 12'h200);
    $display("test plain done");
  endtask : t_plain

  task automatic t_null;
    setp(2, 12'hFC0);
    acc(1'b0, 12'hFD0, 8'h00, 1'b0, 12'h000, 8'h00);
    chk(alu_flags_o[FLAG_Z], 1'b1, "null read zero");
    wr(8'h18, 32'h09);
    acc(1'b1, 12'hFD0, 8'h77, 1'b0, 12'h000, 8'h00);
    chk(alu_flags_o, 8'h09, "null write flags");
    setp(0, 12'hFC5);
    acc(1'b1, 12'hFC2, 8'h40, 1'b0, 12'h000, 8'h00);
    chkp(0, 12'hF40);
    $display("test null done");
  endtask : t_null

  task automatic t_alu;
    foreach (tbl[i]) begin
      @(posedge clk_i);
      alu_valid_i <= 1'b1;
      alu_op_i <= iaf_alu_op_e'(tbl[i][34:32]);
      alu_a_i <= tbl[i][31:24];
      alu_b_i <= tbl[i][23:16];
      @(posedge clk_i);
      alu_valid_i <= 1'b0;
      #1;
      chk(alu_done_o, 1'b1, "alu done");
      chk(alu_result_o, {24'h0, tbl[i][15:8]}, "alu result");
      chk(alu_flags_o, {24'h0, tbl[i][7:0]}, "alu flags");
    end
    // flag write and flag-computing op in one cycle: computed bits win
    @(posedge clk_i);
    acc_valid_i <= 1'b1;
    acc_write_i <= 1'b1;
    acc_addr_i <= FLAGS_ADDR;
    acc_wdata_i <= 8'hFF;
    alu_valid_i <= 1'b1;
    alu_op_i <= ALU_LOGIC;
    alu_b_i <= 8'h00;
    @(posedge clk_i);
    acc_valid_i <= 1'b0;
    alu_valid_i <= 1'b0;
    #1;
    chk(alu_flags_o, 8'h0F, "flag write blocked");
    chk(mem_valid_o, 1'b0, "flag write to memory");
    $display("test alu done");
  endtask : t_alu

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_steps();
    t_index();
    t_plain();
    t_null();
    t_alu();
    finish_test();
  end

  // whole run is under two hundred cycles; ten thousand means a hang
  initial begin
    #1000000;
    err_count++;
    finish_test();
  end
endmodule : test_iaf_core
